//--- bench/dual_serial_channels_tb.sv
// Self-checking bench for the dual serial channel block
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module dual_serial_channels_tb;
    import dual_serial_pkg::*;
    logic clk, rst_n, t1, rx0, oe0, o0, tx0, tx1, p0, p1;
    reg_req_t req;
    logic [DATA_W-1:0] rdata, rv;
    int n_fail = 0;
    int tests_run = 0;
    assign rx0 = oe0 ? o0 : p0;
    dual_serial_channels uut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .timer1_ovf(t1), .chan0_receive_pin_i(rx0), .chan0_receive_pin_o(o0),
        .chan0_receive_pin_oe(oe0), .chan0_transmit_pin(tx0),
        .chan1_receive_pin(p1), .chan1_transmit_pin(tx1));
    serial_peer pr0 (.clk(clk), .line_in(tx0), .line_out(p0));
    serial_peer pr1 (.clk(clk), .line_in(tx1), .line_out(p1));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Timer 1 overflows every second clock
    always @(posedge clk) t1 <= ~t1;
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '{a, d, 1'b0, 1'b0};
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b0};
        #1 d = rdata;
        @(posedge clk);
    endtask : rd
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // Peer sends the inverted byte while the block sends d; ninth tx bit stays 0
    task automatic xfer(input bit ch, input int bc, input bit nine, input logic [7:0] d);
        logic [7:0] v;
        int k;
        pr0.bit_clks = bc;
        pr1.bit_clks = bc;
        wr(ch ? REG_TX1 : REG_TX0, d);
        if (ch)
            pr1.send({2'b11, ~d, 1'b0});
        else
            pr0.send({2'b11, ~d, 1'b0});
        for (k = 0; k < 200; k++)
        begin
            rd(REG_STATUS, v);
            if (v[{ch, 1'b0}] === 1'b0)
                break;
        end
        `CHK("tx idle", 1'b1, k < 200)
        if (k == 200)
            wrap_up;
        `CHK("tx frame", {1'b1, ~nine, d}, ch ? pr1.got : pr0.got)
        `CHK("status", ch ? 8'h28 : 8'h12, v & (ch ? 8'h2c : 8'h13))
        rd(ch ? REG_RX1 : REG_RX0, v);
        `CHK("rx data", ~d, v)
        $display("done xfer ch%0d", ch);
    endtask : xfer
    task automatic t_regs;
        rd(REG_STATUS, rv);
        `CHK("status rst", 8'h00, rv)
        wr(REG_CTRL1, 8'hf8);
        rd(REG_CTRL1, rv);
        `CHK("ctrl1", 8'hf8, rv)
        rd(4'hf, rv);
        `CHK("unmapped", 8'h00, rv)
        $display("done regs");
    endtask : t_regs
    task automatic t_shift;
        logic pv;
        int n_oe;
        pv = 1'b1;
        n_oe = 0;
        // The shift clock would look like frame starts to the peer's receiver
        pr0.listen = 1'b0;
        // Strobe by hand so the first enabled cycle is counted too
        req <= '{REG_TX0, 8'ha9, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
        for (int i = 0; i < 60; i++)
        begin
            #1;
            if (tx0 && !pv)
                rv = {o0, rv[7:1]};
            n_oe += oe0;
            pv = tx0;
            @(posedge clk);
        end
        `CHK("shift data", 8'ha9, rv)
        `CHK("shift length", 48, n_oe)
        fork
            pr0.shift_out(8'h6d);
            wr(REG_CTRL0, 8'h40);
        join
        repeat (6) @(posedge clk);
        rd(REG_RX0, rv);
        `CHK("shift rx", 8'h6d, rv)
        pr0.listen = 1'b1;
        $display("done shift");
    endtask : t_shift
    initial
    begin
        rst_n = 1'b0;
        t1 = 1'b0;
        req = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        // Load early so the old 256-step period has run out before channel 1 is used
        wr(REG_GEN1, RELOAD_ONE);
        t_shift;
        wr(REG_CTRL0, 8'h02);
        xfer(1'b0, 32, 1'b1, 8'h5a);
        wr(REG_CTRL0, 8'h0a);
        xfer(1'b0, 16, 1'b1, 8'hc3);
        wr(REG_GEN0, RELOAD_ONE);
        wr(REG_CTRL0, 8'h07);
        xfer(1'b0, 64, 1'b1, 8'h81);
        wr(REG_CTRL0, 8'h09);
        xfer(1'b0, 32, 1'b0, 8'h3c);
        wr(REG_CTRL1, 8'h02);
        xfer(1'b1, 16, 1'b1, 8'h96);
        wr(REG_CTRL1, 8'h01);
        xfer(1'b1, 32, 1'b0, 8'h4b);
        wrap_up;
    end
endmodule : dual_serial_channels_tb

//--- bench/serial_peer.sv
// Serial peer that sends frames and captures frames mid-bit
`timescale 1ns/1ns
module serial_peer (
    // Clock
    input wire logic clk,
    // Line from and to the block
    input wire logic line_in,
    output logic line_out
);
    int bit_clks = 16;
    int n_got = 0;
    bit listen = 1'b1;
    logic [9:0] got;
    initial line_out = 1'b1;
    task automatic send(input logic [10:0] fr);
        for (int i = 0; i < 11; i++)
        begin
            line_out <= fr[i];
            repeat (bit_clks) @(posedge clk);
        end
    endtask : send
    // Shift mode: each bit goes out as the block's clock falls, idle again once it rises after the eighth bit
    task automatic shift_out(input logic [7:0] b);
        logic pv;
        int i;
        pv = 1'b1;
        i = 0;
        for (int c = 0; c < 64 && i < 9; c++)
        begin
            @(posedge clk);
            #1;
            if (!line_in && pv && i < 8)
            begin
                line_out = b[i];
                i++;
            end
            else if (line_in && !pv && i == 8)
            begin
                line_out = 1'b1;
                i++;
            end
            pv = line_in;
        end
    endtask : shift_out
    // A start that is high again at mid-bit is dropped as a glitch
    initial forever
    begin
        @(negedge line_in);
        repeat (bit_clks / 2) @(posedge clk);
        if (listen && line_in === 1'b0)
        begin
            for (int i = 0; i < 10; i++)
            begin
                repeat (bit_clks) @(posedge clk);
                got[i] = line_in;
            end
            n_got++;
        end
    end
endmodule : serial_peer

//--- rtl/async_chan.sv
// Asynchronous transmitter and receiver driven by one oversampling tick
`timescale 1ns/1ns
module async_chan (
    // Clock and reset
    input logic clk,
    input logic rst_n,
    // Rate and format
    input logic tick,
    input logic nine_bit,
    // Transmit side
    input logic tx_start,
    input logic [8:0] tx_data,
    output logic txd,
    output logic tx_busy,
    // Receive side
    input logic rxd,
    output logic rx_valid,
    output logic [8:0] rx_data
);
    import dual_serial_pkg::*;
    logic [FRAME9-1:0] tx_sh_q;
    logic [3:0] tx_bits_q;
    logic [3:0] tx_ph_q;
    rx_state_t rx_st_q;
    logic [3:0] rx_ph_q;
    logic [3:0] rx_cnt_q;
    logic [9:0] rx_sh_q;
    logic [3:0] rx_last;

    assign tx_busy = (tx_bits_q != 4'h0);
    assign txd = tx_sh_q[0];
    assign rx_last = nine_bit ? 4'(FRAME9 - 2) : 4'(FRAME8 - 2);

    // Sender and receiver own separate counters, so both run at once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_sh_q <= '1;
            tx_bits_q <= '0;
            tx_ph_q <= '0;
        end
        else if (tx_start && !tx_busy)
        begin
            tx_sh_q <= {1'b1, nine_bit ? tx_data[8] : 1'b1, tx_data[7:0], 1'b0};
            tx_bits_q <= nine_bit ? 4'(FRAME9) : 4'(FRAME8);
            tx_ph_q <= '0;
        end
        else if (tick && tx_busy)
        begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == 4'(OVS - 1))
            begin
                tx_sh_q <= {1'b1, tx_sh_q[FRAME9-1:1]};
                tx_bits_q <= tx_bits_q - 4'h1;
            end
        end
    end

    // A frame with a low stop bit is dropped without a report
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_st_q <= RX_IDLE;
            rx_ph_q <= '0;
            rx_cnt_q <= '0;
            rx_sh_q <= '0;
            rx_valid <= 1'b0;
            rx_data <= '0;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (tick)
            begin
                case (rx_st_q)
                    RX_IDLE:
                    begin
                        rx_ph_q <= '0;
                        if (!rxd)
                            rx_st_q <= RX_START;
                    end
                    RX_START:
                    begin
                        rx_ph_q <= rx_ph_q + 4'h1;
                        if (rx_ph_q == 4'(OVS_MID - 1))
                        begin
                            rx_st_q <= rxd ? RX_IDLE : RX_BITS;
                            rx_ph_q <= '0;
                            rx_cnt_q <= '0;
                        end
                    end
                    RX_BITS:
                    begin
                        rx_ph_q <= rx_ph_q + 4'h1;
                        if (rx_ph_q == 4'(OVS - 1))
                        begin
                            rx_sh_q <= {rxd, rx_sh_q[9:1]};
                            rx_cnt_q <= rx_cnt_q + 4'h1;
                            if (rx_cnt_q == rx_last)
                            begin
                                rx_st_q <= RX_IDLE;
                                rx_valid <= rxd;
                                rx_data <= nine_bit ? rx_sh_q[9:1] : {rxd, rx_sh_q[9:2]};
                            end
                        end
                    end
                    default:
                        rx_st_q <= RX_IDLE;
                endcase
            end
        end
    end

    property p_start_bit;
        @(posedge clk) disable iff (!rst_n)
        tx_start && !tx_busy |=> !txd && tx_busy;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit not sent");

    property p_bit_hold;
        @(posedge clk) disable iff (!rst_n)
        tx_busy && !(tick && tx_ph_q == 4'hf) |=> txd == $past(txd);
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("line moved mid bit");
endmodule : async_chan

//--- rtl/baud_gen.sv
// Prescaled reload counter that emits one oversampling tick per overflow
`timescale 1ns/1ns
module baud_gen (
    // Clock and reset
    input logic clk,
    input logic rst_n,
    // Rate selection
    input logic en,
    input logic [2:0] prescale,
    input logic [7:0] reload,
    // Oversampling tick
    output logic tick
);
    import dual_serial_pkg::*;
    logic [2:0] pre_q;
    logic [7:0] cnt_q;
    logic pre_hit;

    // Compare with >= so a smaller prescale never strands the counter
    assign pre_hit = en && (pre_q >= prescale - 3'h1);
    assign tick = pre_hit && (cnt_q == RELOAD_ONE);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pre_q <= '0;
        else if (en)
            pre_q <= pre_hit ? 3'h0 : pre_q + 3'h1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= RELOAD_ONE;
        else if (pre_hit)
            cnt_q <= (cnt_q == RELOAD_ONE) ? reload : cnt_q + 8'h01;
    end
endmodule : baud_gen

//--- rtl/dual_serial_channels.sv
// Two full-duplex serial channels with register port, shift mode and baud selection
// How it works
// - In the UART modes each channel sends and receives independently and at the same time.
// - Channel 0 mode 00 shifts 8 bits LSB first on the receive pin, clocked by the transmit pin.
// - The shift mode bit time is six oscillator cycles whatever the rate bits say.
// - Channel 0 mode 01 is an 8-bit UART with 10-bit frames at a variable rate.
// - Channel 0 mode 10 is a 9-bit UART with 11-bit frames at clock/32, or clock/16 when doubled.
// - Channel 0 mode 11 uses the 9-bit framing with a variable rate.
// - Channel 1 with its mode bit clear is a 9-bit UART with 11-bit frames.
// - Channel 1 with its mode bit set is an 8-bit UART with 10-bit frames.
// - Channel 1 has neither a shift mode nor a fixed-rate mode.
// - Asynchronous modes run from a tick at sixteen times the bit rate.
// - Channel 0 timer source gives a rate of 2^double times timer 1 overflows over 32.
// - Channel 0 generator gives 2^prescale times 2^double times clock over 64 times period.
// - Channel 1 generator gives 2^prescale times clock over 32 times period.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
module dual_serial_channels (
    // Clock and reset
    input logic clk,
    input logic rst_n,
    // Register port
    input dual_serial_pkg::reg_req_t req,
    output logic [dual_serial_pkg::DATA_W-1:0] rdata,
    // Timer 1 overflow pulse on this clock
    input logic timer1_ovf,
    // Channel 0 pins
    input logic chan0_receive_pin_i,
    output logic chan0_receive_pin_o,
    output logic chan0_receive_pin_oe,
    output logic chan0_transmit_pin,
    // Channel 1 pins
    input logic chan1_receive_pin,
    output logic chan1_transmit_pin
);
    import dual_serial_pkg::*;

    function automatic logic wr_at(input reg_req_t r, input logic [ADDR_W-1:0] a);
        return r.wr && (r.addr == a);
    endfunction : wr_at

    function automatic logic rd_at(input reg_req_t r, input logic [ADDR_W-1:0] a);
        return r.rd && (r.addr == a);
    endfunction : rd_at

    ctrl0_t ctrl0_q;
    ctrl0_t ctrl0_wr;
    ctrl1_t ctrl1_q;
    logic [DATA_W-1:0] gen0_q;
    logic [DATA_W-1:0] gen1_q;
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    logic [1:0] mode;
    logic shift_mode;
    logic var_mode;
    shift_state_t sh_st_q;
    logic [2:0] sh_ph_q;
    logic [2:0] sh_ph_d;
    logic [2:0] sh_cnt_q;
    logic [7:0] sh_data_q;
    logic sh_clk_q;
    logic sh_done;
    logic b0_en;
    logic [2:0] b0_pre;
    logic [7:0] b0_reload;
    logic [2:0] b1_pre;
    logic tick0_raw;
    logic tick0;
    logic tick1;
    logic chan0_txd;
    logic async0_busy;
    logic tx1_busy;
    logic rx0_valid;
    logic rx1_valid;
    logic [8:0] rx0_word;
    logic [8:0] rx1_word;
    logic rx_set [2];
    logic [8:0] rx_in [2];
    logic [8:0] rx_q [2];
    logic rx_full_q [2];
    status_t status;

    assign ctrl0_wr = ctrl0_t'(req.wdata);
    assign mode = {ctrl0_q.chan0_mode_sel_hi, ctrl0_q.chan0_mode_sel_lo};
    assign shift_mode = (mode == MODE_SHIFT);
    // Modes 1 and 3 take the variable rate
    assign var_mode = ctrl0_q.chan0_mode_sel_lo;

    // Both receive pins come from outside the clock domain
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
        end
        else
        begin
            pin_meta_q <= {chan1_receive_pin, chan0_receive_pin_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl0_q <= ctrl0_t'(RST_BYTE);
            ctrl1_q <= ctrl1_t'(RST_BYTE);
        end
        else if (wr_at(req, REG_CTRL0))
        begin
            ctrl0_q <= ctrl0_wr;
            // Receive start is a command and is not kept
            ctrl0_q.shift_rx <= 1'b0;
        end
        else if (wr_at(req, REG_CTRL1))
            ctrl1_q <= ctrl1_t'(req.wdata);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gen0_q <= RST_BYTE;
            gen1_q <= RST_BYTE;
        end
        else if (wr_at(req, REG_GEN0))
            gen0_q <= req.wdata;
        else if (wr_at(req, REG_GEN1))
            gen1_q <= req.wdata;
    end

    // Shift mode: one bit every six cycles, clock low for the first half
    assign sh_ph_d = (sh_ph_q == 3'(SHIFT_DIV - 1)) ? 3'h0 : sh_ph_q + 3'h1;
    assign sh_done = (sh_st_q == SH_RX) && (sh_ph_q == 3'(SHIFT_DIV - 1))
                     && (sh_cnt_q == 3'(SHIFT_BITS - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_st_q <= SH_IDLE;
            sh_ph_q <= '0;
            sh_cnt_q <= '0;
            sh_data_q <= '0;
            sh_clk_q <= 1'b1;
        end
        else
        begin
            case (sh_st_q)
                SH_IDLE:
                begin
                    if (shift_mode && wr_at(req, REG_TX0))
                    begin
                        sh_st_q <= SH_TX;
                        sh_data_q <= req.wdata;
                        sh_ph_q <= '0;
                        sh_cnt_q <= '0;
                        sh_clk_q <= 1'b0;
                    end
                    else if (wr_at(req, REG_CTRL0) && ctrl0_wr.shift_rx
                             && {ctrl0_wr.chan0_mode_sel_hi, ctrl0_wr.chan0_mode_sel_lo}
                             == MODE_SHIFT)
                    begin
                        sh_st_q <= SH_RX;
                        sh_ph_q <= '0;
                        sh_cnt_q <= '0;
                        sh_clk_q <= 1'b0;
                    end
                end
                default:
                begin
                    sh_ph_q <= sh_ph_d;
                    sh_clk_q <= (sh_ph_d >= 3'(SHIFT_HALF));
                    // Sample as the clock rises, mid bit for the peer
                    if (sh_st_q == SH_RX && sh_ph_q == 3'(SHIFT_HALF - 1))
                        sh_data_q <= {pin_sync_q[0], sh_data_q[7:1]};
                    if (sh_ph_q == 3'(SHIFT_DIV - 1))
                    begin
                        sh_cnt_q <= sh_cnt_q + 3'h1;
                        if (sh_st_q == SH_TX)
                            sh_data_q <= {1'b0, sh_data_q[7:1]};
                        if (sh_cnt_q == 3'(SHIFT_BITS - 1))
                        begin
                            sh_st_q <= SH_IDLE;
                            sh_clk_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    assign chan0_receive_pin_o = sh_data_q[0];
    assign chan0_receive_pin_oe = (sh_st_q == SH_TX);
    assign chan0_transmit_pin = shift_mode ? sh_clk_q : chan0_txd;

    // Channel 0 tick source; fixed rate unless a variable mode is chosen
    always_comb
    begin
        b0_en = 1'b1;
        b0_pre = 3'(FIX_DIV / OVS) >> ctrl0_q.chan0_rate_double;
        b0_reload = RELOAD_ONE;
        if (var_mode && ctrl0_q.chan0_baud_source_sel)
        begin
            b0_pre = 3'(GEN0_DIV / OVS) >> ({1'b0, ctrl0_q.chan0_gen_prescale}
                     + {1'b0, ctrl0_q.chan0_rate_double});
            b0_reload = gen0_q;
        end
        else if (var_mode)
        begin
            b0_en = timer1_ovf;
            b0_pre = 3'(T1_DIV / OVS) >> ctrl0_q.chan0_rate_double;
        end
    end

    assign b1_pre = 3'(GEN1_DIV / OVS) >> ctrl1_q.chan1_gen_prescale;
    assign tick0 = tick0_raw && !shift_mode;

    baud_gen u_baud0 (
        .clk(clk),
        .rst_n(rst_n),
        .en(b0_en),
        .prescale(b0_pre),
        .reload(b0_reload),
        .tick(tick0_raw)
    );

    baud_gen u_baud1 (
        .clk(clk),
        .rst_n(rst_n),
        .en(1'b1),
        .prescale(b1_pre),
        .reload(gen1_q),
        .tick(tick1)
    );

    // Shift traffic is kept off the UART receiver by holding it idle
    async_chan u_chan0 (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick0),
        .nine_bit(ctrl0_q.chan0_mode_sel_hi),
        .tx_start(wr_at(req, REG_TX0) && !shift_mode),
        .tx_data({ctrl0_q.tx_bit8, req.wdata}),
        .txd(chan0_txd),
        .tx_busy(async0_busy),
        .rxd(pin_sync_q[0] || shift_mode),
        .rx_valid(rx0_valid),
        .rx_data(rx0_word)
    );

    // Only the two variable-rate formats exist on this channel
    async_chan u_chan1 (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick1),
        .nine_bit(!ctrl1_q.chan1_mode_sel),
        .tx_start(wr_at(req, REG_TX1)),
        .tx_data({ctrl1_q.tx_bit8, req.wdata}),
        .txd(chan1_transmit_pin),
        .tx_busy(tx1_busy),
        .rxd(pin_sync_q[1]),
        .rx_valid(rx1_valid),
        .rx_data(rx1_word)
    );

    assign rx_set[0] = shift_mode ? sh_done : rx0_valid;
    assign rx_in[0] = shift_mode ? {1'b0, sh_data_q} : rx0_word;
    assign rx_set[1] = rx1_valid;
    assign rx_in[1] = rx1_word;

    // A new word wins over a read that clears the full flag in the same cycle
    for (genvar g = 0; g < 2; g++)
    begin : g_rx
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                rx_q[g] <= '0;
                rx_full_q[g] <= 1'b0;
            end
            else if (rx_set[g])
            begin
                rx_q[g] <= rx_in[g];
                rx_full_q[g] <= 1'b1;
            end
            else if (rd_at(req, REG_RX0 + ADDR_W'(g)))
                rx_full_q[g] <= 1'b0;
        end
    end

    always_comb
    begin
        status = '0;
        status.tx0_busy = shift_mode ? (sh_st_q != SH_IDLE) : async0_busy;
        status.rx0_full = rx_full_q[0];
        status.tx1_busy = tx1_busy;
        status.rx1_full = rx_full_q[1];
        status.rx0_bit8 = rx_q[0][8];
        status.rx1_bit8 = rx_q[1][8];
    end

    // Read data stands for exactly one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= '0;
        else if (!req.rd)
            rdata <= '0;
        else if (req.addr == REG_CTRL0)
            rdata <= ctrl0_q;
        else if (req.addr == REG_CTRL1)
            rdata <= ctrl1_q;
        else if (req.addr == REG_RX0)
            rdata <= rx_q[0][7:0];
        else if (req.addr == REG_RX1)
            rdata <= rx_q[1][7:0];
        else if (req.addr == REG_STATUS)
            rdata <= status;
        else if (req.addr == REG_GEN0)
            rdata <= gen0_q;
        else if (req.addr == REG_GEN1)
            rdata <= gen1_q;
        else
            rdata <= '0;
    end

    // A start edge seen while sending must still open a receive frame
    property p_full_duplex;
        @(posedge clk) disable iff (!rst_n)
        tx1_busy && tick1 && u_chan1.rx_st_q == RX_IDLE && !pin_sync_q[1]
        |=> u_chan1.rx_st_q == RX_START;
    endproperty
    a_full_duplex: assert property (p_full_duplex) else $error("receive blocked by send");

    property p_shift_lsb;
        @(posedge clk) disable iff (!rst_n)
        shift_mode && sh_st_q == SH_IDLE && wr_at(req, REG_TX0)
        |=> chan0_receive_pin_oe && chan0_receive_pin_o == $past(req.wdata[0]);
    endproperty
    a_shift_lsb: assert property (p_shift_lsb) else $error("shift not LSB first");

    property p_shift_rate;
        @(posedge clk) disable iff (!rst_n)
        shift_mode && $fell(chan0_transmit_pin)
        |-> !chan0_transmit_pin[*3] ##1 chan0_transmit_pin[*3];
    endproperty
    a_shift_rate: assert property (p_shift_rate) else $error("shift clock not six cycles");

    property p_frame0;
        @(posedge clk) disable iff (!rst_n)
        !shift_mode && wr_at(req, REG_TX0) && !async0_busy
        |=> u_chan0.tx_bits_q == (ctrl0_q.chan0_mode_sel_hi ? 4'(FRAME9) : 4'(FRAME8));
    endproperty
    a_frame0: assert property (p_frame0) else $error("channel 0 frame length");

    property p_fixed_rate;
        @(posedge clk) disable iff (!rst_n)
        mode == MODE_FIX9 && !ctrl0_q.chan0_rate_double && tick0 |=> !tick0 ##1 tick0;
    endproperty
    a_fixed_rate: assert property (p_fixed_rate) else $error("fixed rate wrong");

    property p_t1_rate;
        @(posedge clk) disable iff (!rst_n)
        var_mode && !ctrl0_q.chan0_baud_source_sel
        |-> (!tick0 || timer1_ovf) && (!(ctrl0_q.chan0_rate_double && timer1_ovf) || tick0);
    endproperty
    a_t1_rate: assert property (p_t1_rate) else $error("timer 1 rate wrong");

    // A register write may retune the source mid period, so it drops the attempt
    property p_gen0_rate;
        @(posedge clk) disable iff (!rst_n || req.wr)
        var_mode && ctrl0_q.chan0_baud_source_sel && !ctrl0_q.chan0_gen_prescale
        && !ctrl0_q.chan0_rate_double && gen0_q == RELOAD_ONE && tick0
        |=> !tick0[*3] ##1 tick0;
    endproperty
    a_gen0_rate: assert property (p_gen0_rate) else $error("generator 0 rate wrong");

    property p_ch1_rate;
        @(posedge clk) disable iff (!rst_n)
        !ctrl1_q.chan1_gen_prescale && gen1_q == RELOAD_ONE && tick1 |=> !tick1 ##1 tick1;
    endproperty
    a_ch1_rate: assert property (p_ch1_rate) else $error("generator 1 rate wrong");

    property p_ch1_frame;
        @(posedge clk) disable iff (!rst_n)
        wr_at(req, REG_TX1) && !tx1_busy
        |=> u_chan1.tx_bits_q == (ctrl1_q.chan1_mode_sel ? 4'(FRAME8) : 4'(FRAME9));
    endproperty
    a_ch1_frame: assert property (p_ch1_frame) else $error("channel 1 frame length");

    c_shift_rx: cover property (@(posedge clk) disable iff (!rst_n) sh_done);
    c_rx0_async: cover property (@(posedge clk) disable iff (!rst_n) rx0_valid && !shift_mode);
    c_rx1: cover property (@(posedge clk) disable iff (!rst_n) rx1_valid && tx1_busy);
endmodule : dual_serial_channels

//--- rtl/dual_serial_pkg.sv
// Constants and types shared by the dual serial channel block
package dual_serial_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL0 = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CTRL1 = 4'h1;
    localparam logic [ADDR_W-1:0] REG_TX0 = 4'h2;
    localparam logic [ADDR_W-1:0] REG_TX1 = 4'h3;
    localparam logic [ADDR_W-1:0] REG_RX0 = 4'h4;
    localparam logic [ADDR_W-1:0] REG_RX1 = 4'h5;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;
    localparam logic [ADDR_W-1:0] REG_GEN0 = 4'h7;
    localparam logic [ADDR_W-1:0] REG_GEN1 = 4'h8;
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    // Generator reload that overflows on every step
    localparam logic [DATA_W-1:0] RELOAD_ONE = 8'hff;
    localparam int OVS = 16;
    localparam int OVS_MID = OVS / 2;
    localparam int SHIFT_DIV = 6;
    localparam int SHIFT_HALF = SHIFT_DIV / 2;
    localparam int SHIFT_BITS = 8;
    localparam int FIX_DIV = 32;
    localparam int T1_DIV = 32;
    localparam int GEN0_DIV = 64;
    localparam int GEN1_DIV = 32;
    localparam int FRAME8 = 10;
    localparam int FRAME9 = 11;
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_FIX9 = 2'h2;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
    typedef enum logic [1:0] {SH_IDLE, SH_TX, SH_RX} shift_state_t;
    typedef struct packed {
        logic spare;
        logic shift_rx;
        logic tx_bit8;
        logic chan0_gen_prescale;
        logic chan0_rate_double;
        logic chan0_baud_source_sel;
        logic chan0_mode_sel_hi;
        logic chan0_mode_sel_lo;
    } ctrl0_t;
    typedef struct packed {
        logic [4:0] spare;
        logic tx_bit8;
        logic chan1_gen_prescale;
        logic chan1_mode_sel;
    } ctrl1_t;
    typedef struct packed {
        logic [1:0] spare;
        logic rx1_bit8;
        logic rx0_bit8;
        logic rx1_full;
        logic tx1_busy;
        logic rx0_full;
        logic tx0_busy;
    } status_t;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage : dual_serial_pkg
